// >>> inc/cfg_regs_pkg.sv
// Purpose: Shared constants, types and helpers for the configuration register group
// Assumes: Byte offsets within configuration space, 32-bit words
// Notes: Used by the register bank, its decoder and its read multiplexer
package cfg_regs_pkg;
	// Widths
	localparam int ADDR_W = 8;
	localparam int NUM_REGS = 6;
	localparam int LEN_W = 10;
	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [31:0] word_t;
	typedef logic [NUM_REGS-1:0] sel_t;
	typedef logic [3:0] be_t;
	typedef logic [LEN_W-1:0] len_t;
	// Register byte offsets
	localparam addr_t OFF_MSI_DATA = 8'h58;
	localparam addr_t OFF_VSC_HDR = 8'h64;
	localparam addr_t OFF_SCRATCH0 = 8'h68;
	localparam addr_t OFF_SCRATCH1 = 8'h6C;
	localparam addr_t OFF_TIMER = 8'h70;
	localparam addr_t OFF_MODE = 8'h74;
	// Positions in the one-hot select vector
	localparam int IDX_MSI = 0;
	localparam int IDX_VSC = 1;
	localparam int IDX_SCR0 = 2;
	localparam int IDX_SCR1 = 3;
	localparam int IDX_TIMER = 4;
	localparam int IDX_MODE = 5;
	// Vendor capability header contents
	localparam logic [7:0] VSC_CAP_ID = 8'h09;
	localparam logic [7:0] VSC_NEXT_PTR = 8'hB0;
	localparam logic [15:0] VSC_LENGTH = 16'h0034;
	// Reset values
	localparam word_t RST_MSI = 32'h0000_0000;
	localparam word_t RST_SCR0 = 32'h0400_1060;
	localparam word_t RST_SCR1 = 32'h0000_0800;
	localparam word_t RST_TIMER = 32'h0000_0000;
	localparam word_t RST_MODE = 32'h0000_0002;
	localparam logic VGA_DECODE_VAL = 1'b1;
	// Bits that host software may write
	localparam word_t HOST_WMASK_MSI = 32'h0000_FFFF;
	localparam word_t HOST_WMASK_SCR = 32'hFFFF_FFFF;
	localparam word_t HOST_WMASK_TIMER = 32'h7FFF_1FFF;
	localparam word_t HOST_WMASK_MODE = 32'h0000_007F;
	// Bits that the default loader may write
	localparam word_t LD_WMASK_TIMER = 32'h7FFF_7FFF;
	localparam word_t LD_WMASK_MODE = 32'h0000_007F;
	// Timer register fields
	localparam int TMR_REPLAY_LSB = 0;
	localparam int TMR_REPLAY_W = 12;
	localparam int TMR_REPLAY_EN = 12;
	localparam int TMR_PM_DIS = 13;
	localparam int TMR_MSI_DIS = 14;
	localparam int TMR_ACK_LSB = 16;
	localparam int TMR_ACK_W = 14;
	localparam int TMR_ACK_EN = 30;
	localparam int TMR_VGA = 31;
	// Operation mode fields
	localparam int MODE_SF = 0;
	localparam int MODE_THR_LSB = 1;
	localparam int MODE_THR_W = 2;
	localparam int MODE_ARB = 3;
	localparam int MODE_CREDIT = 4;
	localparam int MODE_ORD_EGR = 5;
	localparam int MODE_ORD_TAG = 6;
	// Message data field
	localparam int MSI_DATA_W = 16;

	// Map a byte offset to a one-hot register select, zero when unmapped
	function automatic sel_t addr_to_sel(input addr_t a);
		sel_t s;
		s = '0;
		s[IDX_MSI] = (a == OFF_MSI_DATA);
		s[IDX_VSC] = (a == OFF_VSC_HDR);
		s[IDX_SCR0] = (a == OFF_SCRATCH0);
		s[IDX_SCR1] = (a == OFF_SCRATCH1);
		s[IDX_TIMER] = (a == OFF_TIMER);
		s[IDX_MODE] = (a == OFF_MODE);
		return s;
	endfunction

	// Expand byte enables into a bit mask
	function automatic word_t be_to_mask(input be_t be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Replace the masked bits of a word
	function automatic word_t merge_bits(input word_t old_w, input word_t new_w, input word_t m);
		return (old_w & ~m) | (new_w & m);
	endfunction
endpackage

// >>> inc/cfg_access_if.sv
// Purpose: Decoded access stage passed from the decoder to the register bank
// Assumes: One clock domain
// Notes: Host and loader paths travel side by side
`timescale 1ns/100ps
`default_nettype none
interface cfg_access_if;
	import cfg_regs_pkg::*;
	sel_t host_sel;    // One-hot target of the host access
	logic host_wr;     // Host write in this stage
	logic host_rd;     // Host read in this stage
	word_t host_mask;  // Byte enables as a bit mask
	word_t host_wdata; // Host write data
	sel_t ld_sel;      // One-hot target of the loader write
	word_t ld_data;    // Loader write data
	modport decoder (output host_sel, host_wr, host_rd, host_mask, host_wdata, ld_sel, ld_data);
	modport bank (input host_sel, host_wr, host_rd, host_mask, host_wdata, ld_sel, ld_data);
endinterface
`default_nettype wire

// >>> core/cfg_decode.sv
// Purpose: Register and decode host and loader accesses for the register bank
// Assumes: Requests come from logic on clk_sys
// Notes: One stage of latency, accepts a request every cycle
`timescale 1ns/100ps
`default_nettype none
module cfg_decode
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Host request
	input wire logic cfg_req,
	input wire logic cfg_wr,
	input wire cfg_regs_pkg::addr_t cfg_addr,
	input wire cfg_regs_pkg::be_t cfg_be,
	input wire cfg_regs_pkg::word_t cfg_wdata,
	// Loader request
	input wire logic ld_req,
	input wire cfg_regs_pkg::addr_t ld_addr,
	input wire cfg_regs_pkg::word_t ld_data,
	// Decoded stage
	cfg_access_if.decoder acc
);
	import cfg_regs_pkg::*;

	// Host stage, unmapped offsets give an empty select
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc.host_sel <= '0;
			acc.host_wr <= 1'b0;
			acc.host_rd <= 1'b0;
			acc.host_mask <= '0;
			acc.host_wdata <= '0;
		end
		else
		begin
			acc.host_sel <= cfg_req ? addr_to_sel(cfg_addr) : '0;
			acc.host_wr <= cfg_req & cfg_wr;
			acc.host_rd <= cfg_req & ~cfg_wr;
			acc.host_mask <= be_to_mask(cfg_be);
			acc.host_wdata <= cfg_wdata;
		end
	end

	// Loader stage, whole words only
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc.ld_sel <= '0;
			acc.ld_data <= '0;
		end
		else
		begin
			acc.ld_sel <= ld_req ? addr_to_sel(ld_addr) : '0;
			acc.ld_data <= ld_data;
		end
	end
endmodule
`default_nettype wire

// >>> core/cfg_read_mux.sv
// Purpose: Select the read word of the addressed register
// Assumes: Select is one-hot or empty
// Notes: Unmapped offsets read as zero
`timescale 1ns/100ps
`default_nettype none
module cfg_read_mux
(
	// Decoded stage
	cfg_access_if.bank acc,
	// Register words as seen by software
	input wire cfg_regs_pkg::word_t msi_word,
	input wire cfg_regs_pkg::word_t scr0_word,
	input wire cfg_regs_pkg::word_t scr1_word,
	input wire cfg_regs_pkg::word_t timer_word,
	input wire cfg_regs_pkg::word_t mode_word,
	// Selected word
	output logic [31:0] rd_word
);
	import cfg_regs_pkg::*;

	// OR of masked words, the header is built from constants
	always_comb
	begin
		rd_word = '0;
		if (acc.host_sel[IDX_MSI])
			rd_word = rd_word | msi_word;
		if (acc.host_sel[IDX_VSC])
			rd_word = rd_word | {VSC_LENGTH, VSC_NEXT_PTR, VSC_CAP_ID};
		if (acc.host_sel[IDX_SCR0])
			rd_word = rd_word | scr0_word;
		if (acc.host_sel[IDX_SCR1])
			rd_word = rd_word | scr1_word;
		if (acc.host_sel[IDX_TIMER])
			rd_word = rd_word | timer_word;
		if (acc.host_sel[IDX_MODE])
			rd_word = rd_word | mode_word;
	end
endmodule
`default_nettype wire

// >>> core/switch_vendor_config_regs.sv
// Purpose: Vendor configuration register group of the switch upstream port
// Assumes: Host and loader requests are synchronous to clk_sys
// Notes: Access answer two cycles after the request, loader overrides defaults
`timescale 1ns/100ps
`default_nettype none
module switch_vendor_config_regs
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Configuration access from host software
	input wire logic cfg_req,
	input wire logic cfg_wr,
	input wire cfg_regs_pkg::addr_t cfg_addr,
	input wire cfg_regs_pkg::be_t cfg_be,
	input wire cfg_regs_pkg::word_t cfg_wdata,
	output logic cfg_ack,
	output var cfg_regs_pkg::word_t cfg_rdata,
	// Default loading from SMBus or EEPROM
	input wire logic ld_req,
	input wire cfg_regs_pkg::addr_t ld_addr,
	input wire cfg_regs_pkg::word_t ld_data,
	// Link layer timer limits
	input wire logic [11:0] builtin_replay_limit,
	input wire logic [13:0] builtin_ack_limit,
	output logic [11:0] replay_limit,
	output logic [13:0] ack_limit,
	// Forwarding engine
	input wire cfg_regs_pkg::len_t pkt_len_cycles,
	output var cfg_regs_pkg::len_t fwd_start_cycle,
	output logic store_forward,
	output logic [1:0] ct_threshold,
	// Arbitration, credit and ordering policy
	output logic arb_hold_port,
	output logic credit_all_types,
	output logic order_egress,
	output logic order_cpl_tag,
	// Capability and decode control
	output logic pm_cap_disable,
	output logic msi_cap_disable,
	output logic vga_decode_en,
	output logic [15:0] msi_message_data
);
	import cfg_regs_pkg::*;

	// Decoded access stage
	cfg_access_if acc ();

	// Stored register words
	word_t msi_reg;   // Message data, low half used
	word_t scr0_reg;  // First scratch word
	word_t scr1_reg;  // Second scratch word
	word_t timer_reg; // Timer overrides, read-only bits kept at zero
	word_t mode_reg;  // Operation mode, low bits used

	// Next values
	word_t msi_next;
	word_t scr0_next;
	word_t scr1_next;
	word_t timer_next;
	word_t mode_next;

	// Words as software sees them
	word_t msi_view;
	word_t timer_view;
	word_t mode_view;
	word_t rd_word;

	// Host write strobes per register
	logic wr_msi;
	logic wr_scr0;
	logic wr_scr1;
	logic wr_timer;
	logic wr_mode;

	// Cut-through start point
	len_t half_len;
	len_t ct_start;
	logic [1:0] thr_sel;

	// Decode and register the incoming requests
	cfg_decode u_decode
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cfg_req(cfg_req),
		.cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr),
		.cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata),
		.ld_req(ld_req),
		.ld_addr(ld_addr),
		.ld_data(ld_data),
		.acc(acc)
	);

	// Pick the addressed word for reads
	cfg_read_mux u_read_mux
	(
		.acc(acc),
		.msi_word(msi_view),
		.scr0_word(scr0_reg),
		.scr1_word(scr1_reg),
		.timer_word(timer_view),
		.mode_word(mode_view),
		.rd_word(rd_word)
	);

	// Host write strobes, the header has none
	always_comb
	begin
		wr_msi = acc.host_wr & acc.host_sel[IDX_MSI];
		wr_scr0 = acc.host_wr & acc.host_sel[IDX_SCR0];
		wr_scr1 = acc.host_wr & acc.host_sel[IDX_SCR1];
		wr_timer = acc.host_wr & acc.host_sel[IDX_TIMER];
		wr_mode = acc.host_wr & acc.host_sel[IDX_MODE];
	end

	// Software views, reserved bits cleared and fixed bits inserted
	always_comb
	begin
		msi_view = msi_reg & HOST_WMASK_MSI;
		timer_view = timer_reg & LD_WMASK_TIMER;
		timer_view[TMR_VGA] = VGA_DECODE_VAL;
		mode_view = mode_reg & LD_WMASK_MODE;
	end

	// Message data next value
	always_comb
	begin
		msi_next = msi_reg;
		if (wr_msi)
			msi_next = merge_bits(msi_reg, acc.host_wdata, acc.host_mask & HOST_WMASK_MSI);
	end

	// Scratch next values, host writes only
	always_comb
	begin
		scr0_next = scr0_reg;
		scr1_next = scr1_reg;
		if (wr_scr0)
			scr0_next = merge_bits(scr0_reg, acc.host_wdata, acc.host_mask & HOST_WMASK_SCR);
		if (wr_scr1)
			scr1_next = merge_bits(scr1_reg, acc.host_wdata, acc.host_mask & HOST_WMASK_SCR);
	end

	// Timer next value, host first, then the loader on top
	always_comb
	begin
		timer_next = timer_reg;
		if (wr_timer)
			timer_next = merge_bits(timer_next, acc.host_wdata, acc.host_mask & HOST_WMASK_TIMER);
		if (acc.ld_sel[IDX_TIMER])
			timer_next = merge_bits(timer_next, acc.ld_data, LD_WMASK_TIMER);
	end

	// Mode next value, host first, then the loader on top
	always_comb
	begin
		mode_next = mode_reg;
		if (wr_mode)
			mode_next = merge_bits(mode_next, acc.host_wdata, acc.host_mask & HOST_WMASK_MODE);
		if (acc.ld_sel[IDX_MODE])
			mode_next = merge_bits(mode_next, acc.ld_data, LD_WMASK_MODE);
	end

	// Message data storage
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			msi_reg <= RST_MSI;
		else
			msi_reg <= msi_next;
	end

	// Scratch storage
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scr0_reg <= RST_SCR0;
			scr1_reg <= RST_SCR1;
		end
		else
		begin
			scr0_reg <= scr0_next;
			scr1_reg <= scr1_next;
		end
	end

	// Timer override storage
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			timer_reg <= RST_TIMER;
		else
			timer_reg <= timer_next;
	end

	// Operation mode storage
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			mode_reg <= RST_MODE;
		else
			mode_reg <= mode_next;
	end

	// Answer to the host, two cycles after the request
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_ack <= 1'b0;
			cfg_rdata <= '0;
		end
		else
		begin
			cfg_ack <= acc.host_wr | acc.host_rd;
			// Read data only on reads, zero otherwise
			cfg_rdata <= acc.host_rd ? rd_word : '0;
		end
	end

	// Effective link layer limits, user values only when enabled
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			replay_limit <= '0;
			ack_limit <= '0;
		end
		else
		begin
			// Replay time-out
			if (timer_reg[TMR_REPLAY_EN])
				replay_limit <= timer_reg[TMR_REPLAY_LSB +: TMR_REPLAY_W];
			else
				replay_limit <= builtin_replay_limit;
			// Acknowledge latency
			if (timer_reg[TMR_ACK_EN])
				ack_limit <= timer_reg[TMR_ACK_LSB +: TMR_ACK_W];
			else
				ack_limit <= builtin_ack_limit;
		end
	end

	// Midpoint pulled earlier by the threshold, clamped at zero
	always_comb
	begin
		thr_sel = mode_reg[MODE_THR_LSB +: MODE_THR_W];
		half_len = pkt_len_cycles >> 1;
		if (half_len > len_t'(thr_sel))
			ct_start = half_len - len_t'(thr_sel);
		else
			ct_start = '0;
	end

	// Forwarding start cycle, whole packet in store-forward mode
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			fwd_start_cycle <= '0;
		else if (mode_reg[MODE_SF])
			fwd_start_cycle <= pkt_len_cycles;
		else
			fwd_start_cycle <= ct_start;
	end

	// Forwarding mode controls taken from the mode register
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			store_forward <= 1'b0;
			ct_threshold <= RST_MODE[MODE_THR_LSB +: MODE_THR_W];
		end
		else
		begin
			store_forward <= mode_reg[MODE_SF];
			ct_threshold <= mode_reg[MODE_THR_LSB +: MODE_THR_W];
		end
	end

	// Arbitration, credit and ordering policy controls
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arb_hold_port <= 1'b0;
			credit_all_types <= 1'b0;
			order_egress <= 1'b0;
			order_cpl_tag <= 1'b0;
		end
		else
		begin
			arb_hold_port <= mode_reg[MODE_ARB];
			credit_all_types <= mode_reg[MODE_CREDIT];
			order_egress <= mode_reg[MODE_ORD_EGR];
			order_cpl_tag <= mode_reg[MODE_ORD_TAG];
		end
	end

	// Capability disables, decode enable and message data
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pm_cap_disable <= 1'b0;
			msi_cap_disable <= 1'b0;
			vga_decode_en <= VGA_DECODE_VAL;
			msi_message_data <= '0;
		end
		else
		begin
			// Capability disables changed only by the loader
			pm_cap_disable <= timer_reg[TMR_PM_DIS];
			msi_cap_disable <= timer_reg[TMR_MSI_DIS];
			vga_decode_en <= VGA_DECODE_VAL;
			msi_message_data <= msi_reg[MSI_DATA_W-1:0];
		end
	end
endmodule
`default_nettype wire

// >>> bench/switch_vendor_config_regs_props.sv
// Purpose: Concurrent checks on the ports of the vendor configuration register group
// Assumes: One clock domain, asynchronous active-low reset, offset 60h left unmapped
// Notes: Bound from the bench top file; sees only the top module's ports
`timescale 1ns/100ps
`default_nettype none
module switch_vendor_config_regs_props
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Host and loader requests
	input wire logic cfg_req,
	input wire logic cfg_wr,
	input wire cfg_regs_pkg::addr_t cfg_addr,
	input wire cfg_regs_pkg::be_t cfg_be,
	input wire cfg_regs_pkg::word_t cfg_wdata,
	input wire logic cfg_ack,
	input wire cfg_regs_pkg::word_t cfg_rdata,
	input wire logic ld_req,
	input wire cfg_regs_pkg::addr_t ld_addr,
	// Limits and forwarding
	input wire logic [11:0] builtin_replay_limit,
	input wire logic [13:0] builtin_ack_limit,
	input wire logic [11:0] replay_limit,
	input wire logic [13:0] ack_limit,
	input wire cfg_regs_pkg::len_t pkt_len_cycles,
	input wire cfg_regs_pkg::len_t fwd_start_cycle,
	input wire logic store_forward,
	input wire logic [1:0] ct_threshold,
	input wire logic vga_decode_en
);
	import cfg_regs_pkg::*;
	logic [1:0] up_cnt; // Edges since reset release, saturating
	word_t wd1, wd2, wd3; // Write data delayed by one, two and three edges
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Keep history checks away from values taken during reset
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			up_cnt <= 2'h0;
		else if (up_cnt != 2'h3)
			up_cnt <= up_cnt + 2'h1;
	end
	// Delay line of host write data for the timer checks
	always_ff @(posedge clk_sys)
	begin
		wd1 <= cfg_wdata;
		wd2 <= wd1;
		wd3 <= wd2;
	end
	// Host read of one offset
	sequence rd_at(addr_t a);
		cfg_req && !cfg_wr && cfg_addr == a;
	endsequence
	// Timer write covering the given lanes, with no loader write racing it
	sequence tmr_wr(be_t b);
		cfg_req && cfg_wr && cfg_addr == OFF_TIMER && (cfg_be & b) == b && !(ld_req && ld_addr == OFF_TIMER)
		##1 !(ld_req && ld_addr == OFF_TIMER);
	endsequence
	ack_timing_a: assert property (up_cnt == 2'h3 |-> cfg_ack == $past(cfg_req, 2))
		else $error("cfg_ack does not follow cfg_req by two cycles");
	hdr_read_a: assert property (rd_at(OFF_VSC_HDR) |-> ##2 cfg_rdata == 32'h0034_B009)
		else $error("capability header read wrong");
	tmr_ro_a: assert property (rd_at(OFF_TIMER) |-> ##2 cfg_rdata[31] && !cfg_rdata[15])
		else $error("timer fixed bits read wrong");
	mode_rsvd_a: assert property (rd_at(OFF_MODE) |-> ##2 cfg_rdata[31:7] == 25'h0)
		else $error("mode reserved bits not zero");
	unmapped_zero_a: assert property (rd_at(8'h60) |-> ##2 cfg_rdata == 32'h0)
		else $error("unmapped offset read not zero");
	vga_const_a: assert property (vga_decode_en)
		else $error("vga decode enable dropped");
	fwd_start_a: assert property (up_cnt == 2'h3 |-> fwd_start_cycle == (store_forward ? $past(pkt_len_cycles) :
		(($past(pkt_len_cycles) >> 1) > ct_threshold ? ($past(pkt_len_cycles) >> 1) - ct_threshold : 10'h0)))
		else $error("forwarding start cycle wrong");
	replay_sel_a: assert property (tmr_wr(4'h3) |-> ##2
		replay_limit == (wd3[12] ? wd3[11:0] : $past(builtin_replay_limit)))
		else $error("replay limit source wrong");
	ack_sel_a: assert property (tmr_wr(4'hC) |-> ##2
		ack_limit == (wd3[30] ? wd3[29:16] : $past(builtin_ack_limit)))
		else $error("ack latency limit source wrong");
endmodule
`default_nettype wire

// >>> bench/cfg_host_model.sv
// Purpose: Host software and default loader standing at the far side of the register group
// Assumes: Requests are one-cycle pulses launched on the falling edge
// Notes: Released address and data lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model
(
	// Clock
	input wire logic clk_sys,
	// Host access
	output logic cfg_req,
	output logic cfg_wr,
	output var cfg_regs_pkg::addr_t cfg_addr,
	output var cfg_regs_pkg::be_t cfg_be,
	output var cfg_regs_pkg::word_t cfg_wdata,
	input wire logic cfg_ack,
	input wire cfg_regs_pkg::word_t cfg_rdata,
	// Default loader
	output logic ld_req,
	output var cfg_regs_pkg::addr_t ld_addr,
	output var cfg_regs_pkg::word_t ld_data
);
	import cfg_regs_pkg::*;
	// Idle at time zero
	initial
	begin
		cfg_req = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		ld_req = 1'b0;
		ld_addr = 8'h00;
		ld_data = 32'h0;
	end
	// One host access, waiting a bounded time for the answer
	task automatic access(input logic wr, input addr_t a, input be_t be, input word_t wd, output word_t rd,
		output logic ok);
		int n;
		@(negedge clk_sys);
		cfg_req = 1'b1;
		cfg_wr = wr;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = wd;
		@(negedge clk_sys);
		cfg_req = 1'b0;
		cfg_addr = ~a;
		cfg_wdata = ~wd;
		ok = 1'b0;
		rd = 32'h0;
		for (n = 0; n < 4 && !ok; n++)
		begin
			@(negedge clk_sys);
			ok = (cfg_ack === 1'b1);
			rd = cfg_rdata;
		end
	endtask
	// One whole-word default load
	task automatic load(input addr_t a, input word_t d);
		@(negedge clk_sys);
		ld_req = 1'b1;
		ld_addr = a;
		ld_data = d;
		@(negedge clk_sys);
		ld_req = 1'b0;
		ld_addr = ~a;
		ld_data = ~d;
	endtask
endmodule
`default_nettype wire

// >>> bench/switch_vendor_config_regs_tb_top.sv
// Purpose: Self-checking bench for the vendor configuration register group
// Assumes: Offset 60h is unmapped; a shadow copy predicts every read
// Notes: Two passes, the second entered through a reset in mid-run
`timescale 1ns/100ps
`default_nettype none
module switch_vendor_config_regs_tb_top;
	import cfg_regs_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_req, cfg_wr, cfg_ack, ld_req;
	addr_t cfg_addr, ld_addr;
	be_t cfg_be;
	word_t cfg_wdata, cfg_rdata, ld_data;
	logic [11:0] builtin_replay_limit = 12'h0, replay_limit;
	logic [13:0] builtin_ack_limit = 14'h0, ack_limit;
	len_t pkt_len_cycles = 10'h0, fwd_start_cycle;
	logic store_forward, arb_hold_port, credit_all_types, order_egress, order_cpl_tag;
	logic pm_cap_disable, msi_cap_disable, vga_decode_en;
	logic [1:0] ct_threshold;
	logic [15:0] msi_message_data;
	int seed = 87991;
	int err_total = 0;
	int checks = 0;
	// Offsets, reset words and writable masks, last entry unmapped
	localparam addr_t ADDRS [7] = '{8'h58, 8'h64, 8'h68, 8'h6C, 8'h70, 8'h74, 8'h60};
	localparam word_t RSTV [7] = '{32'h0, 32'h0034_B009, 32'h0400_1060, 32'h0000_0800, 32'h0, 32'h2, 32'h0};
	localparam word_t HMASK [7] = '{32'hFFFF, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h7FFF_1FFF, 32'h7F, 32'h0};
	localparam word_t LMASK [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h7FFF_7FFF, 32'h7F, 32'h0};
	word_t sh [7]; // Shadow of each register
	always #2 clk_sys = ~clk_sys;
	// Link-layer and forwarding inputs wander at random
	always @(negedge clk_sys)
	begin
		builtin_replay_limit = 12'($random(seed));
		builtin_ack_limit = 14'($random(seed));
		pkt_len_cycles = 10'($random(seed));
	end
	cfg_host_model host (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .ld_req(ld_req),
		.ld_addr(ld_addr), .ld_data(ld_data));
	switch_vendor_config_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.ld_req(ld_req), .ld_addr(ld_addr), .ld_data(ld_data), .builtin_replay_limit(builtin_replay_limit),
		.builtin_ack_limit(builtin_ack_limit), .replay_limit(replay_limit), .ack_limit(ack_limit),
		.pkt_len_cycles(pkt_len_cycles), .fwd_start_cycle(fwd_start_cycle), .store_forward(store_forward),
		.ct_threshold(ct_threshold), .arb_hold_port(arb_hold_port), .credit_all_types(credit_all_types),
		.order_egress(order_egress), .order_cpl_tag(order_cpl_tag), .pm_cap_disable(pm_cap_disable),
		.msi_cap_disable(msi_cap_disable), .vga_decode_en(vga_decode_en), .msi_message_data(msi_message_data));
	// Count a comparison and report a mismatch
	task automatic chk(input string what, input word_t exp, input word_t got);
		checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask
	// Print the verdict and stop
	task automatic give_verdict;
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Software view of a register: timer top bit always reads one
	function automatic word_t exp_rd(input int i);
		return (i == 4) ? (sh[i] | 32'h8000_0000) : sh[i];
	endfunction
	// Field copies settle one edge after the register changes
	task automatic chk_outs;
		repeat (2) @(negedge clk_sys);
		chk("field copies", {6'h0, 1'b1, sh[0][15:0], sh[4][14], sh[4][13], sh[5][6:0]}, {6'h0, vga_decode_en,
			msi_message_data, msi_cap_disable, pm_cap_disable, order_cpl_tag, order_egress, credit_all_types,
			arb_hold_port, ct_threshold, store_forward});
	endtask
	// Read one register and compare with the shadow
	task automatic rd_chk(input int i);
		word_t rd;
		logic ok;
		host.access(1'b0, ADDRS[i], 4'($random(seed)), $random(seed), rd, ok);
		chk("read ack", 32'h1, {31'h0, ok});
		chk($sformatf("read %h", ADDRS[i]), exp_rd(i), rd);
	endtask
	// Host write through byte lanes, then read back
	task automatic wr_chk(input int i, input be_t be, input word_t d);
		word_t rd;
		logic ok;
		word_t m;
		m = HMASK[i] & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		host.access(1'b1, ADDRS[i], be, d, rd, ok);
		chk("write ack", 32'h1, {31'h0, ok});
		chk("write rdata", 32'h0, rd);
		sh[i] = (sh[i] & ~m) | (d & m);
		chk_outs();
		rd_chk(i);
	endtask
	// Default load of a whole word, then read back
	task automatic ld_chk(input int i, input word_t d);
		host.load(ADDRS[i], d);
		sh[i] = (sh[i] & ~LMASK[i]) | (d & LMASK[i]);
		chk_outs();
		rd_chk(i);
	endtask
	// Main sequence
	initial
	begin
		int pass, i, n;
		for (pass = 0; pass < 2; pass++)
		begin
			rst_n = 1'b0;
			repeat (5) @(negedge clk_sys);
			rst_n = 1'b1;
			for (i = 0; i < 7; i++)
				sh[i] = RSTV[i];
			chk_outs();
			for (i = 0; i < 7; i++)
				rd_chk(i);
			// Every offset written all ones, then all zeros
			for (i = 0; i < 14; i++)
				wr_chk(i % 7, 4'hF, (i < 7) ? 32'hFFFF_FFFF : 32'h0);
			// Loader overrides every field it may touch, loads zero at scratch 68h, then clears only the timer fields
			ld_chk(4, 32'hFFFF_FFFF);
			ld_chk(5, 32'hFFFF_FFFF);
			ld_chk(2, 32'h0);
			ld_chk(4, 32'h0);
			// Random mix of host writes, loads and reads
			for (n = 0; n < 60; n++)
			begin
				i = {$random(seed)} % 7;
				case ({$random(seed)} % 3)
					0: wr_chk(i, 4'($random(seed)), $random(seed));
					1: ld_chk(i, $random(seed));
					default: rd_chk(i);
				endcase
			end
		end
		give_verdict();
	end
	// Watchdog: both passes need about 1100 cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		give_verdict();
	end
endmodule
bind switch_vendor_config_regs switch_vendor_config_regs_props props (.clk_sys(clk_sys), .rst_n(rst_n),
	.cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
	.cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .ld_req(ld_req), .ld_addr(ld_addr),
	.builtin_replay_limit(builtin_replay_limit), .builtin_ack_limit(builtin_ack_limit),
	.replay_limit(replay_limit), .ack_limit(ack_limit), .pkt_len_cycles(pkt_len_cycles),
	.fwd_start_cycle(fwd_start_cycle), .store_forward(store_forward), .ct_threshold(ct_threshold),
	.vga_decode_en(vga_decode_en));
`default_nettype wire
